// ---- inc/olar_map.svh ----
// register offsets, reset values, field layouts and scaling constants
// assumes byte-wide register access from the device's serial interface
`ifndef OLAR_MAP_SVH
`define OLAR_MAP_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OLAR_OFS_OTG_LO 8'h08
`define OLAR_OFS_OTG_HI 8'h09
`define OLAR_OFS_SYS_PWR 8'h26
`define OLAR_OFS_BUS_V 8'h27
`define OLAR_OFS_DCHG_I 8'h28
`define OLAR_OFS_CHG_I 8'h29
`define OLAR_OFS_CMP_V 8'h2a
`define OLAR_OFS_IN_I 8'h2b

// -----------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------
`define OLAR_OTG_RST 7'h00
`define OLAR_OTG_LO_RST 8'h00
`define OLAR_OTG_BAD_BIT 7
`define OLAR_OTG_MSB 6
`define OLAR_RES_RST 8'h00
`define OLAR_CUR_MASK 8'h7f
`define OLAR_ALL_MASK 8'hff
`define OLAR_ZERO_BYTE 8'h00
`define OLAR_CUR_MSB 6
`define OLAR_OTG_MA_RST 13'h0000
`define OLAR_BUS_MV_RST 15'h0000
`define OLAR_SYS_MV_RST 12'h000
`define OLAR_CMP_MV_RST 12'h000
`define OLAR_CHG_MA_RST 13'h0000
`define OLAR_DCHG_MA_RST 15'h0000
`define OLAR_IN_MA_RST 14'h0000

// -----------------------------------------------------------------
// result channel indices
// -----------------------------------------------------------------
`define OLAR_NCH 6
`define OLAR_CH_SYS_PWR 0
`define OLAR_CH_BUS_V 1
`define OLAR_CH_DCHG_I 2
`define OLAR_CH_CHG_I 3
`define OLAR_CH_CMP_V 4
`define OLAR_CH_IN_I 5

// -----------------------------------------------------------------
// scaling: lsb weights and offsets
// -----------------------------------------------------------------
`define OLAR_OTG_LSB_MA 13'd50
`define OLAR_BUS_LSB_MV 15'd64
`define OLAR_BUS_OFS_MV 15'd3200
`define OLAR_SYS_LSB_MV 12'd12
`define OLAR_CMP_LSB_MV 12'd12
`define OLAR_CHG_LSB_MA 13'd64
`define OLAR_DCHG_LSB_MA 15'd256
`define OLAR_IN_LSB_MA 14'd50

`endif

// ---- inc/olar_pkg.sv ----
// types shared by the otg limit and result readback block
// assumes the map header supplies all numeric constants
package olar_pkg;

  // one-hot register select
  typedef enum logic [8:0] {
    SEL_NONE    = 9'h001,
    SEL_OTG_LO  = 9'h002,
    SEL_OTG_HI  = 9'h004,
    SEL_SYS_PWR = 9'h008,
    SEL_BUS_V   = 9'h010,
    SEL_DCHG_I  = 9'h020,
    SEL_CHG_I   = 9'h040,
    SEL_CMP_V   = 9'h080,
    SEL_IN_I    = 9'h100
  } olar_sel_t;

  typedef logic [7:0] olar_byte_t;

endpackage

// ---- inc/olar_adc_if.sv ----
// carrier for conversion results between result bank and register slice
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface olar_adc_if;
  logic [5:0][7:0] res;
  logic [5:0] seen;
  modport bank (output res, output seen);
  modport regs (input res, input seen);
endinterface

// ---- core/olar_adc_bank.sv ----
// result bank: holds the latest conversion byte of each channel
// assumes measurement logic on the same clock, strobes one cycle wide
`timescale 1ns/10ps
`include "olar_map.svh"
module olar_adc_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] upd_i,
  input wire logic [5:0][7:0] meas_i,
  olar_adc_if.bank res_if
);

  // -----------------------------------------------------------------
  // per-channel storage
  // -----------------------------------------------------------------
  logic [5:0][7:0] res_q;
  logic [5:0] seen_q;

  function automatic logic [7:0] ch_mask(input int ch);
    if (ch == `OLAR_CH_DCHG_I || ch == `OLAR_CH_CHG_I) begin
      return `OLAR_CUR_MASK;
    end
    return `OLAR_ALL_MASK;
  endfunction

  genvar g;
  generate
    for (g = 0; g < `OLAR_NCH; g++) begin : g_ch
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          res_q[g] <= `OLAR_RES_RST;
          seen_q[g] <= 1'b0;
        end else if (upd_i[g]) begin
          res_q[g] <= meas_i[g] & ch_mask(g);
          seen_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign res_if.res = res_q;
  assign res_if.seen = seen_q;

endmodule

// ---- core/olar_regs.sv ----
// otg current limit register and conversion result readback slice
// assumes byte accesses from the device serial interface, same clock
//
// Behaviour
// - the otg limit is a 7-bit code in bits 6..0 of the upper byte, 50 mA per count, applied as a sum.
// - the lower otg byte is unused and writes to it change nothing.
// - reset clears both otg bytes to zero.
// - input bus voltage reads as an 8-bit code, 64 mV per count from 3200 mV to 19520 mV.
// - system power monitor reads as an 8-bit code, 12 mV per count, 3.06 V full range.
// - charge current reads as a 7-bit code, 64 mA per count, 8.128 A full range, bit 7 unused.
// - discharge current reads as a 7-bit code, 256 mA per count, 32.512 A full range, bit 7 unused.
// - input current reads as an 8-bit code, 50 mA per count, 12.75 A full range.
// - comparator input voltage reads as an 8-bit code, 12 mV per count, 3.06 V full range.
// - result bytes are read-only and change only from the measurement logic.
`timescale 1ns/10ps
`include "olar_map.svh"
module olar_regs (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_ACK_O,
  output logic REG_INVALID_O,
  input wire logic [5:0] MEAS_UPDATE_I,
  input wire logic [7:0] MEAS_SYS_PWR_I,
  input wire logic [7:0] MEAS_BUS_V_I,
  input wire logic [7:0] MEAS_DCHG_I_I,
  input wire logic [7:0] MEAS_CHG_I_I,
  input wire logic [7:0] MEAS_CMP_V_I,
  input wire logic [7:0] MEAS_IN_I_I,
  output logic [6:0] OTG_LIMIT_CODE_O,
  output logic [12:0] OTG_LIMIT_MA_O,
  output logic [14:0] BUS_V_MV_O,
  output logic [11:0] SYS_PWR_MV_O,
  output logic [12:0] CHG_I_MA_O,
  output logic [14:0] DCHG_I_MA_O,
  output logic [13:0] IN_I_MA_O,
  output logic [11:0] CMP_V_MV_O,
  output logic [5:0] RES_SEEN_O
);

  // -----------------------------------------------------------------
  // result bank
  // -----------------------------------------------------------------
  olar_adc_if res_if ();
  logic [5:0][7:0] meas_w;

  always_comb begin
    meas_w[`OLAR_CH_SYS_PWR] = MEAS_SYS_PWR_I;
    meas_w[`OLAR_CH_BUS_V] = MEAS_BUS_V_I;
    meas_w[`OLAR_CH_DCHG_I] = MEAS_DCHG_I_I;
    meas_w[`OLAR_CH_CHG_I] = MEAS_CHG_I_I;
    meas_w[`OLAR_CH_CMP_V] = MEAS_CMP_V_I;
    meas_w[`OLAR_CH_IN_I] = MEAS_IN_I_I;
  end

  olar_adc_bank u_bank (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .upd_i(MEAS_UPDATE_I),
    .meas_i(meas_w),
    .res_if(res_if.bank)
  );

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  function automatic olar_pkg::olar_sel_t decode(input logic [7:0] a);
    case (a)
      `OLAR_OFS_OTG_LO: decode = olar_pkg::SEL_OTG_LO;
      `OLAR_OFS_OTG_HI: decode = olar_pkg::SEL_OTG_HI;
      `OLAR_OFS_SYS_PWR: decode = olar_pkg::SEL_SYS_PWR;
      `OLAR_OFS_BUS_V: decode = olar_pkg::SEL_BUS_V;
      `OLAR_OFS_DCHG_I: decode = olar_pkg::SEL_DCHG_I;
      `OLAR_OFS_CHG_I: decode = olar_pkg::SEL_CHG_I;
      `OLAR_OFS_CMP_V: decode = olar_pkg::SEL_CMP_V;
      `OLAR_OFS_IN_I: decode = olar_pkg::SEL_IN_I;
      default: decode = olar_pkg::SEL_NONE;
    endcase
  endfunction

  // upper partner of a lower result byte, for coherent pair reads
  function automatic olar_pkg::olar_sel_t upper_of(input olar_pkg::olar_sel_t s);
    case (s)
      olar_pkg::SEL_SYS_PWR: upper_of = olar_pkg::SEL_BUS_V;
      olar_pkg::SEL_DCHG_I: upper_of = olar_pkg::SEL_CHG_I;
      olar_pkg::SEL_CMP_V: upper_of = olar_pkg::SEL_IN_I;
      default: upper_of = olar_pkg::SEL_NONE;
    endcase
  endfunction

  olar_pkg::olar_sel_t sel;
  olar_pkg::olar_sel_t partner;
  assign sel = decode(REG_ADDR_I);
  assign partner = upper_of(sel);

  logic req;
  assign req = REG_RD_I || REG_WR_I;

  // -----------------------------------------------------------------
  // otg current limit
  // -----------------------------------------------------------------
  logic [6:0] otg_lim_q;
  logic otg_hi_wr;
  logic otg_bad;

  // write strobe aimed at the upper otg byte
  assign otg_hi_wr = REG_WR_I && (sel == olar_pkg::SEL_OTG_HI);

  // bit 7 set on the upper byte marks the write invalid
  assign otg_bad = otg_hi_wr && REG_WDATA_I[`OLAR_OTG_BAD_BIT];

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      otg_lim_q <= `OLAR_OTG_RST;
    end else if (otg_hi_wr && !otg_bad) begin
      otg_lim_q <= REG_WDATA_I[`OLAR_OTG_MSB:0];
    end
  end

  // lower otg byte has no storage: writes are dropped, reads give zero

  // -----------------------------------------------------------------
  // invalid write flag
  // -----------------------------------------------------------------
  logic invalid_q;

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      invalid_q <= 1'b0;
    end else begin
      invalid_q <= otg_bad;
    end
  end

  // -----------------------------------------------------------------
  // read value of a register
  // -----------------------------------------------------------------
  function automatic logic [7:0] read_byte(input olar_pkg::olar_sel_t s,
                                           input logic [6:0] lim,
                                           input logic [5:0][7:0] r);
    case (s)
      olar_pkg::SEL_OTG_LO: read_byte = `OLAR_OTG_LO_RST;
      olar_pkg::SEL_OTG_HI: read_byte = {1'b0, lim};
      olar_pkg::SEL_SYS_PWR: read_byte = r[`OLAR_CH_SYS_PWR];
      olar_pkg::SEL_BUS_V: read_byte = r[`OLAR_CH_BUS_V];
      olar_pkg::SEL_DCHG_I: read_byte = r[`OLAR_CH_DCHG_I] & `OLAR_CUR_MASK;
      olar_pkg::SEL_CHG_I: read_byte = r[`OLAR_CH_CHG_I] & `OLAR_CUR_MASK;
      olar_pkg::SEL_CMP_V: read_byte = r[`OLAR_CH_CMP_V];
      olar_pkg::SEL_IN_I: read_byte = r[`OLAR_CH_IN_I];
      default: read_byte = `OLAR_ZERO_BYTE;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // pair snapshot: reading a lower result byte freezes its upper byte
  // -----------------------------------------------------------------
  logic [7:0] hold_q;
  olar_pkg::olar_sel_t hold_sel_q;
  logic hold_hit;
  logic snap;

  // a read of a lower result byte snapshots its upper byte
  assign snap = REG_RD_I && (partner != olar_pkg::SEL_NONE);
  assign hold_hit = REG_RD_I && (hold_sel_q != olar_pkg::SEL_NONE) &&
                    (sel == hold_sel_q);

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      hold_q <= `OLAR_ZERO_BYTE;
    end else if (snap) begin
      hold_q <= read_byte(partner, otg_lim_q, res_if.res);
    end
  end

  // any other access drops the snapshot
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      hold_sel_q <= olar_pkg::SEL_NONE;
    end else if (snap) begin
      hold_sel_q <= partner;
    end else if (req) begin
      hold_sel_q <= olar_pkg::SEL_NONE;
    end
  end

  // -----------------------------------------------------------------
  // read data and acknowledge
  // -----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic ack_q;

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      rdata_q <= `OLAR_ZERO_BYTE;
    end else if (REG_RD_I) begin
      if (hold_hit) begin
        rdata_q <= hold_q;
      end else begin
        rdata_q <= read_byte(sel, otg_lim_q, res_if.res);
      end
    end
  end

  // writes to result bytes are acknowledged and go nowhere
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // -----------------------------------------------------------------
  // applied limit and scaled results
  // -----------------------------------------------------------------
  logic [12:0] otg_ma_q;
  logic [14:0] bus_mv_q;
  logic [11:0] sys_mv_q;
  logic [12:0] chg_ma_q;
  logic [14:0] dchg_ma_q;
  logic [13:0] in_ma_q;
  logic [11:0] cmp_mv_q;

  // 7-bit current code, bit 7 of the byte is not part of it
  function automatic logic [6:0] cur_code(input logic [7:0] b);
    cur_code = b[`OLAR_CUR_MSB:0];
  endfunction

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      otg_ma_q <= `OLAR_OTG_MA_RST;
    end else begin
      otg_ma_q <= 13'(otg_lim_q) * `OLAR_OTG_LSB_MA;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      bus_mv_q <= `OLAR_BUS_MV_RST;
    end else begin
      bus_mv_q <= `OLAR_BUS_OFS_MV +
                  15'(res_if.res[`OLAR_CH_BUS_V]) * `OLAR_BUS_LSB_MV;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      sys_mv_q <= `OLAR_SYS_MV_RST;
    end else begin
      sys_mv_q <= 12'(res_if.res[`OLAR_CH_SYS_PWR]) * `OLAR_SYS_LSB_MV;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      cmp_mv_q <= `OLAR_CMP_MV_RST;
    end else begin
      cmp_mv_q <= 12'(res_if.res[`OLAR_CH_CMP_V]) * `OLAR_CMP_LSB_MV;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      chg_ma_q <= `OLAR_CHG_MA_RST;
    end else begin
      chg_ma_q <= 13'(cur_code(res_if.res[`OLAR_CH_CHG_I])) * `OLAR_CHG_LSB_MA;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      dchg_ma_q <= `OLAR_DCHG_MA_RST;
    end else begin
      dchg_ma_q <= 15'(cur_code(res_if.res[`OLAR_CH_DCHG_I])) * `OLAR_DCHG_LSB_MA;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      in_ma_q <= `OLAR_IN_MA_RST;
    end else begin
      in_ma_q <= 14'(res_if.res[`OLAR_CH_IN_I]) * `OLAR_IN_LSB_MA;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign REG_RDATA_O = rdata_q;
  assign REG_ACK_O = ack_q;
  assign REG_INVALID_O = invalid_q;
  assign OTG_LIMIT_CODE_O = otg_lim_q;
  assign OTG_LIMIT_MA_O = otg_ma_q;
  assign BUS_V_MV_O = bus_mv_q;
  assign SYS_PWR_MV_O = sys_mv_q;
  assign CHG_I_MA_O = chg_ma_q;
  assign DCHG_I_MA_O = dchg_ma_q;
  assign IN_I_MA_O = in_ma_q;
  assign CMP_V_MV_O = cmp_mv_q;
  assign RES_SEEN_O = res_if.seen;

endmodule

// ---- verification/olar_chk.sv ----
// concurrent checks on the otg limit and result readback ports
// assumes bind to olar_regs, one clock domain
`timescale 1ns/10ps
module olar_chk (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic REG_ACK_O,
  input wire logic REG_INVALID_O,
  input wire logic [5:0] MEAS_UPDATE_I,
  input wire logic [7:0] MEAS_BUS_V_I,
  input wire logic [7:0] MEAS_CHG_I_I,
  input wire logic [6:0] OTG_LIMIT_CODE_O,
  input wire logic [12:0] OTG_LIMIT_MA_O,
  input wire logic [14:0] BUS_V_MV_O,
  input wire logic [12:0] CHG_I_MA_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  sequence s_req;
    REG_RD_I || REG_WR_I;
  endsequence
  sequence s_otg_wr;
    REG_WR_I && REG_ADDR_I == 8'h09;
  endsequence
  property p_ack;
    s_req |=> REG_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_idle;
    !(REG_RD_I || REG_WR_I) |=> !REG_ACK_O && !REG_INVALID_O;
  endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_good;
    s_otg_wr ##0 !REG_WDATA_I[7] |=> OTG_LIMIT_CODE_O == 7'($past(REG_WDATA_I));
  endproperty
  a_good: assert property (p_good) else $error("otg code not stored");
  property p_bad;
    s_otg_wr ##0 REG_WDATA_I[7] |=> REG_INVALID_O && $stable(OTG_LIMIT_CODE_O);
  endproperty
  a_bad: assert property (p_bad) else $error("invalid otg write taken");
  property p_lo;
    REG_WR_I && REG_ADDR_I == 8'h08 |=> $stable(OTG_LIMIT_CODE_O);
  endproperty
  a_lo: assert property (p_lo) else $error("low otg byte changed limit");
  property p_ma;
    $stable(OTG_LIMIT_CODE_O) [*2] |-> OTG_LIMIT_MA_O == 13'(OTG_LIMIT_CODE_O) * 13'h0032;
  endproperty
  a_ma: assert property (p_ma) else $error("otg limit sum wrong");
  property p_rst;
    disable iff (1'b0) !NRST_I |=> OTG_LIMIT_CODE_O == 7'h00 && OTG_LIMIT_MA_O == 13'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("otg limit not cleared");
  property p_bus;
    MEAS_UPDATE_I[1] |-> ##2 BUS_V_MV_O == 15'h0c80 + 15'($past(MEAS_BUS_V_I, 2)) * 15'h0040;
  endproperty
  a_bus: assert property (p_bus) else $error("bus voltage scale wrong");
  property p_chg;
    MEAS_UPDATE_I[3] |-> ##2 CHG_I_MA_O == 13'($past(MEAS_CHG_I_I, 2) & 8'h7f) * 13'h0040;
  endproperty
  a_chg: assert property (p_chg) else $error("charge current scale wrong");
endmodule

bind olar_regs olar_chk olar_chk_i (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RD_I(REG_RD_I), .REG_ACK_O(REG_ACK_O), .REG_INVALID_O(REG_INVALID_O),
  .MEAS_UPDATE_I(MEAS_UPDATE_I), .MEAS_BUS_V_I(MEAS_BUS_V_I), .MEAS_CHG_I_I(MEAS_CHG_I_I),
  .OTG_LIMIT_CODE_O(OTG_LIMIT_CODE_O), .OTG_LIMIT_MA_O(OTG_LIMIT_MA_O),
  .BUS_V_MV_O(BUS_V_MV_O), .CHG_I_MA_O(CHG_I_MA_O));

// ---- verification/olar_host_model.sv ----
// host controller model issuing byte accesses
// assumes strobes taken on the edge after they are driven
`timescale 1ns/10ps
module olar_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic ack_i,
  input wire logic inv_i,
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  // one access, answer sampled one edge after it is taken
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ak, output logic iv);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
    q = rdata_i;
    ak = ack_i;
    iv = inv_i;
  endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the otg limit and result readback slice
// assumes olar_regs top ports and the host model
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata, q, d;
  logic wr, rd, ack, inv, ak, iv;
  logic [5:0] upd = 6'h00;
  logic [5:0][7:0] meas = '0;
  logic [6:0] code;
  logic [12:0] ma, chg;
  logic [14:0] busv, dchg;
  logic [11:0] sysp, cmp;
  logic [13:0] input_current;
  logic [5:0] seen;
  int fails = 0;
  int compares = 0;
  logic [7:0] ra [6] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b};
  logic [5:0][7:0] mv [2] = '{{6{8'hff}}, {8'h5a, 8'h3c, 8'hc5, 8'h9e, 8'h81, 8'h27}};
  logic [7:0] re [2][6] = '{'{8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff},
    '{8'h27, 8'h81, 8'h1e, 8'h45, 8'h3c, 8'h5a}};
  logic [15:0] se [2][6] = '{'{16'h0bf4, 16'h4c40, 16'h7f00, 16'h1fc0, 16'h0bf4, 16'h31ce},
    '{16'h01d4, 16'h2cc0, 16'h1e00, 16'h1140, 16'h02d0, 16'h1194}};
  olar_regs olar_regs_i (.REF_CLK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
    .REG_INVALID_O(inv), .MEAS_UPDATE_I(upd), .MEAS_SYS_PWR_I(meas[0]),
    .MEAS_BUS_V_I(meas[1]), .MEAS_DCHG_I_I(meas[2]), .MEAS_CHG_I_I(meas[3]),
    .MEAS_CMP_V_I(meas[4]), .MEAS_IN_I_I(meas[5]), .OTG_LIMIT_CODE_O(code),
    .OTG_LIMIT_MA_O(ma), .BUS_V_MV_O(busv), .SYS_PWR_MV_O(sysp), .CHG_I_MA_O(chg),
    .DCHG_I_MA_O(dchg), .IN_I_MA_O(input_current), .CMP_V_MV_O(cmp), .RES_SEEN_O(seen));
  olar_host_model olar_host_model_i (.clk_i(clk), .rdata_i(rdata), .ack_i(ack),
    .inv_i(inv), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] scaled(input int c);
    case (c)
      0: scaled = {4'h0, sysp};
      1: scaled = {1'b0, busv};
      2: scaled = {1'b0, dchg};
      3: scaled = {3'h0, chg};
      4: scaled = {4'h0, cmp};
      default: scaled = {2'h0, input_current};
    endcase
  endfunction
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("bus mv", 16'h0c80, {1'b0, busv});
    chk("seen rst", 16'h0000, {10'h000, seen});
    olar_host_model_i.acc(1'b0, 8'h09, 8'h00, q, ak, iv);
    chk("otg hi", 16'h0000, {8'h00, q});
    olar_host_model_i.acc(1'b0, 8'h08, 8'h00, q, ak, iv);
    chk("otg lo", 16'h0000, {8'h00, q});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 7) ? 8'h7f : 8'h01 << i;
      olar_host_model_i.acc(1'b1, 8'h09, d, q, ak, iv);
      chk("otg inv", 16'h0000, {15'h0000, iv});
      @(posedge clk);
      chk("otg code", {8'h00, d}, {9'h000, code});
      chk("otg ma", 16'(d) * 16'h0032, {3'h0, ma});
      olar_host_model_i.acc(1'b0, 8'h09, 8'h00, q, ak, iv);
      chk("otg rd", {8'h00, d}, {8'h00, q});
    end
    olar_host_model_i.acc(1'b1, 8'h09, 8'h85, q, ak, iv);
    chk("bad inv", 16'h0001, {15'h0000, iv});
    chk("bad code", 16'h007f, {9'h000, code});
    olar_host_model_i.acc(1'b1, 8'h08, 8'hff, q, ak, iv);
    olar_host_model_i.acc(1'b0, 8'h08, 8'h00, q, ak, iv);
    chk("lo rd", 16'h0000, {8'h00, q});
    chk("lo code", 16'h007f, {9'h000, code});
    $display("test otg done");
    for (int p = 0; p < 2; p++) begin
      meas <= mv[p];
      upd <= 6'h3f;
      @(posedge clk);
      upd <= 6'h00;
      repeat (3) @(posedge clk);
      chk("seen", 16'h003f, {10'h000, seen});
      for (int c = 0; c < 6; c++) begin
        chk("scaled", se[p][c], scaled(c));
        olar_host_model_i.acc(1'b0, ra[c], 8'h00, q, ak, iv);
        chk("res rd", {8'h00, re[p][c]}, {8'h00, q});
        if (c == 2 || c == 3) begin
          chk("res code", {9'h000, mv[p][c][6:0]}, {9'h000, q[6:0]});
        end
        olar_host_model_i.acc(1'b1, ra[c], 8'h00, q, ak, iv);
        chk("res ack", 16'h0001, {15'h0000, ak});
        olar_host_model_i.acc(1'b0, ra[c], 8'h00, q, ak, iv);
        chk("res keep", {8'h00, re[p][c]}, {8'h00, q});
      end
    end
    olar_host_model_i.acc(1'b0, 8'h26, 8'h00, q, ak, iv);
    meas[1] <= 8'h10;
    upd <= 6'h02;
    @(posedge clk);
    upd <= 6'h00;
    olar_host_model_i.acc(1'b0, 8'h27, 8'h00, q, ak, iv);
    chk("pair snap", 16'h0081, {8'h00, q});
    olar_host_model_i.acc(1'b0, 8'h27, 8'h00, q, ak, iv);
    chk("pair new", 16'h0010, {8'h00, q});
    olar_host_model_i.acc(1'b0, 8'h30, 8'h00, q, ak, iv);
    chk("unmapped", 16'h0001, {7'h00, q, ak});
    $display("test results done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("rst code", 16'h0000, {9'h000, code});
    chk("rst ma", 16'h0000, {3'h0, ma});
    chk("rst seen", 16'h0000, {10'h000, seen});
    olar_host_model_i.acc(1'b0, 8'h2b, 8'h00, q, ak, iv);
    chk("rst res", 16'h0000, {8'h00, q});
    olar_host_model_i.acc(1'b0, 8'h09, 8'h00, q, ak, iv);
    chk("rst otg", 16'h0000, {8'h00, q});
    $display("test second reset done");
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule
